// *** src/spu_cfg.svh ***
// Constants for the sector protection unit.
`ifndef SPU_CFG_SVH
`define SPU_CFG_SVH
`define SPU_MODE_NONE      2'h3
`define SPU_MODE_PERSIST   2'h2
`define SPU_MODE_PASSWORD  2'h1
`define SPU_MODE_ILLEGAL   2'h0
`define SPU_SECRET_RESET   64'hffffffffffffffff
`define SPU_UNLOCK_US      100
`define SPU_CLK_MHZ        200
`define SPU_PROG_CYCLES    16'h0040
`define SPU_ERASE_CYCLES   16'h0100
`define SPU_ONE            16'h0001
`define SPU_ZERO16         16'h0000
`endif

// *** src/spu_pkg.sv ***
// Types shared by the sector protection unit.
package spu_pkg;
	typedef enum logic [3:0]
	{
		SPU_CMD_NONE       = 4'h0,
		SPU_CMD_PSB_PROG   = 4'h1,
		SPU_CMD_PSB_ERASE  = 4'h2,
		SPU_CMD_LOCK_CLEAR = 4'h3,
		SPU_CMD_UNLOCK     = 4'h4,
		SPU_CMD_DSB_WRITE  = 4'h5,
		SPU_CMD_MODE_PROG  = 4'h6,
		SPU_CMD_SECRET_PROG = 4'h7,
		SPU_CMD_SECRET_READ = 4'h8,
		SPU_CMD_CFG_WRITE  = 4'h9
	} spu_cmd_t;

	typedef struct packed
	{
		spu_cmd_t    cmd;
		logic [9:0]  sector;
		logic        value;
		logic [63:0] data;
	} spu_req_t;

	typedef enum logic [1:0]
	{
		SPU_ST_IDLE   = 2'b00,
		SPU_ST_BUSY   = 2'b01,
		SPU_ST_UNLOCK = 2'b10
	} spu_state_t;
endpackage

// *** src/spu_timer.sv ***
// Down counter that times one embedded operation.
`timescale 1ns/100ps
`default_nettype none
`include "spu_cfg.svh"
module spu_timer #(
	parameter int W = 16
) (
	// Clock and control
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         ce_i,
	// Start and status
	input  wire logic         start_i,
	input  wire logic [W-1:0] count_i,
	output logic              done_o
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         run_q;
	logic         run_d;
	wire          last = (cnt_q == W'(`SPU_ONE));
	assign cnt_d  = start_i ? count_i : (run_q ? cnt_q - W'(`SPU_ONE) : cnt_q);
	assign run_d  = start_i ? 1'b1 : (run_q && !last);
	assign done_o = run_q && last;
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end
		else if (ce_i)
		begin
			cnt_q <= cnt_d;
			run_q <= run_d;
		end
	end
endmodule // spu_timer
`default_nettype wire

// *** src/spu_top.sv ***
// Per-sector program and erase protection with lock and password control.
`timescale 1ns/100ps
`default_nettype none
`include "spu_cfg.svh"
module spu_top
	import spu_pkg::*;
#(
	parameter int N_SECT   = 1024,
	parameter int SW       = 10,
	parameter int AW       = 32,
	parameter int UNLOCK_CYC = `SPU_UNLOCK_US * `SPU_CLK_MHZ
) (
	// Clock, reset, enable
	input  wire logic          ref_clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          ce_i,
	input  wire logic          soft_rst_i,
	// Command request
	input  wire logic          req_valid_i,
	input  var  spu_req_t      req_i,
	input  wire logic          write_en_i,
	// Non-volatile mode bits as loaded from storage
	input  wire logic [1:0]    mode_bits_i,
	// Protection query
	input  wire logic [SW-1:0] query_sector_i,
	input  wire logic          block_hit_i,
	input  wire logic          read_protect_i,
	input  wire logic [AW-1:0] read_addr_i,
	input  wire logic [AW-1:0] boot_addr_i,
	// Status
	output logic               sector_protected_o,
	output logic               wip_o,
	output logic               perr_o,
	output logic               lock_o,
	output logic               password_mode_o,
	output logic [1:0]         mode_bits_o,
	output logic               cfg_write_ok_o,
	output logic [63:0]        secret_rdata_o,
	output logic [AW-1:0]      eff_read_addr_o,
	output logic               ecc_status_ok_o
);
	logic [N_SECT-1:0] psb_q;
	logic [N_SECT-1:0] dsb_q;
	logic [63:0]       secret_q;
	logic [1:0]        mode_q;
	logic              lock_q;
	logic              perr_q;
	logic              busy_q;
	logic              mode_ld_q;
	spu_state_t        st_q;
	spu_req_t          op_q;
	logic [31:0]       pace_q;
	logic              tmr_start;
	logic [15:0]       tmr_count;
	logic              tmr_done;

	// Mode bits are caught just after the release of reset, never by the reset itself.
	wire mode_sel    = (mode_q != `SPU_MODE_NONE);
	wire pw_mode     = (mode_q == `SPU_MODE_PASSWORD);
	wire accept      = req_valid_i && ce_i && (st_q == SPU_ST_IDLE) && mode_ld_q;
	wire is_psb      = (req_i.cmd == SPU_CMD_PSB_PROG) || (req_i.cmd == SPU_CMD_PSB_ERASE);
	wire psb_refused = is_psb && !lock_q;
	wire cfg_refused = mode_sel && ((req_i.cmd == SPU_CMD_MODE_PROG) ||
		(req_i.cmd == SPU_CMD_SECRET_PROG) || (req_i.cmd == SPU_CMD_CFG_WRITE));
	wire [1:0] new_mode   = mode_q & req_i.data[1:0];
	wire mode_illegal = (req_i.cmd == SPU_CMD_MODE_PROG) &&
		(new_mode == `SPU_MODE_ILLEGAL);
	wire nv_cmd      = is_psb || (req_i.cmd == SPU_CMD_MODE_PROG) ||
		(req_i.cmd == SPU_CMD_SECRET_PROG);
	wire no_wel      = nv_cmd && !write_en_i;
	wire match       = (req_i.data == secret_q);
	wire sect_guard  = !(psb_q[query_sector_i] && dsb_q[query_sector_i]);

	assign sector_protected_o = block_hit_i || sect_guard;
	assign eff_read_addr_o    = read_protect_i ? boot_addr_i : read_addr_i;
	assign ecc_status_ok_o    = !read_protect_i || (read_addr_i == boot_addr_i);
	assign wip_o              = busy_q;
	assign perr_o             = perr_q;
	assign lock_o             = lock_q;
	assign password_mode_o    = pw_mode;
	assign mode_bits_o        = mode_q;
	assign cfg_write_ok_o     = !mode_sel;
	assign tmr_count          = (req_i.cmd == SPU_CMD_PSB_ERASE) ? `SPU_ERASE_CYCLES :
		`SPU_PROG_CYCLES;
	assign tmr_start          = accept && !no_wel && !psb_refused && !cfg_refused &&
		!mode_illegal && (nv_cmd);

	spu_timer #(
		.W (16)
	) u_timer (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.start_i   (tmr_start),
		.count_i   (tmr_count),
		.done_o    (tmr_done)
	);

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			psb_q     <= '1;
			dsb_q     <= '1;
			secret_q  <= `SPU_SECRET_RESET;
			mode_q    <= `SPU_MODE_NONE;
			lock_q    <= 1'b1;
			perr_q    <= 1'b0;
			busy_q    <= 1'b0;
			mode_ld_q <= 1'b0;
			st_q      <= SPU_ST_IDLE;
			op_q      <= '0;
			pace_q    <= '0;
			secret_rdata_o <= '0;
		end
		else if (ce_i)
		begin
			if (!mode_ld_q)
			begin
				mode_ld_q <= 1'b1;
				mode_q    <= mode_bits_i;
				lock_q    <= (mode_bits_i != `SPU_MODE_PASSWORD);
			end
			if (soft_rst_i && st_q == SPU_ST_IDLE)
			begin
				dsb_q <= '1;
				perr_q <= 1'b0;
			end
			case (st_q)
				SPU_ST_IDLE:
				begin
					if (accept)
					begin
						op_q <= req_i;
						if (no_wel)
						begin
							perr_q <= perr_q;
						end
						else if (psb_refused || cfg_refused || mode_illegal)
						begin
							perr_q <= 1'b1;
						end
						else
						begin
							case (req_i.cmd)
								SPU_CMD_PSB_PROG,
								SPU_CMD_PSB_ERASE,
								SPU_CMD_MODE_PROG,
								SPU_CMD_SECRET_PROG:
								begin
									busy_q <= 1'b1;
									st_q   <= SPU_ST_BUSY;
								end
								SPU_CMD_LOCK_CLEAR:
									lock_q <= 1'b0;
								SPU_CMD_DSB_WRITE:
									dsb_q[req_i.sector] <= req_i.value;
								SPU_CMD_SECRET_READ:
									if (!pw_mode)
										secret_rdata_o <= secret_q;
								SPU_CMD_UNLOCK:
								begin
									busy_q <= 1'b1;
									if (pw_mode && match)
									begin
										lock_q <= 1'b1;
										busy_q <= 1'b0;
									end
									else
									begin
										perr_q <= 1'b1;
										pace_q <= 32'(UNLOCK_CYC);
										st_q   <= SPU_ST_UNLOCK;
									end
								end
								default:
									perr_q <= perr_q;
							endcase
						end
					end
				end
				SPU_ST_BUSY:
				begin
					if (tmr_done)
					begin
						busy_q <= 1'b0;
						st_q   <= SPU_ST_IDLE;
						case (op_q.cmd)
							SPU_CMD_PSB_PROG:
								psb_q[op_q.sector] <= 1'b0;
							SPU_CMD_PSB_ERASE:
								psb_q <= '1;
							SPU_CMD_MODE_PROG:
								mode_q <= mode_q & op_q.data[1:0];
							SPU_CMD_SECRET_PROG:
								secret_q <= secret_q & op_q.data;
							default:
								busy_q <= 1'b0;
						endcase
					end
				end
				SPU_ST_UNLOCK:
				begin
					if (pace_q <= 32'h1)
					begin
						busy_q <= 1'b0;
						st_q   <= SPU_ST_IDLE;
					end
					else
						pace_q <= pace_q - 32'h1;
				end
				default:
					st_q <= SPU_ST_IDLE;
			endcase
		end
	end

	// Counts enabled cycles spent pacing a failed unlock, apart from the pacing counter,
	// so that a slip in that counter cannot hide from the pacing check.
	logic [31:0] pace_seen_q;
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			pace_seen_q <= '0;
		else if (ce_i)
			pace_seen_q <= (st_q == SPU_ST_UNLOCK) ? pace_seen_q + 32'h1 : 32'h0;
	end

	a_bad_unlock_busy: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(st_q == SPU_ST_UNLOCK) |-> (wip_o && perr_o))
		else $error("bad unlock not busy");
	a_locked_psb_same: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(accept && psb_refused && !no_wel) |=> ($stable(psb_q) && perr_o))
		else $error("locked psb changed");
	a_lock_no_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(mode_ld_q && !pw_mode && !lock_q) |=> !lock_q)
		else $error("lock set in persist mode");
	a_guard_or: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		block_hit_i |-> sector_protected_o)
		else $error("block range ignored");
	a_mode_never_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		mode_ld_q && (mode_bits_i != `SPU_MODE_ILLEGAL) |-> mode_q != `SPU_MODE_ILLEGAL)
		else $error("illegal mode");
	a_cfg_reject: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(accept && cfg_refused && !no_wel) |=> (perr_o && $stable(mode_q) && $stable(secret_q)))
		else $error("config changed");
	a_dsb_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(accept && req_i.cmd == SPU_CMD_DSB_WRITE) |=> dsb_q[$past(req_i.sector)] == $past(req_i.value))
		else $error("dsb write lost");
	a_good_unlock: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(accept && req_i.cmd == SPU_CMD_UNLOCK && pw_mode && match) |=> (lock_o && !wip_o))
		else $error("unlock failed");
	a_prog_done: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		tmr_start |=> wip_o [*8])
		else $error("wip dropped early");
	a_psb_frozen: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(mode_ld_q && !lock_q) |=> $stable(psb_q))
		else $error("persistent bits changed while locked");
	a_soft_keeps_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(soft_rst_i && !req_valid_i && mode_ld_q) |=> $stable(lock_q))
		else $error("soft reset changed lock");
	a_reset_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!mode_ld_q && ce_i) |=> (lock_q == (mode_q != `SPU_MODE_PASSWORD)))
		else $error("lock not set by mode at reset");
	a_erase_all_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(ce_i && tmr_done && st_q == SPU_ST_BUSY && op_q.cmd == SPU_CMD_PSB_ERASE) |=> (&psb_q))
		else $error("erase left a persistent bit at zero");
	a_secret_no_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		mode_ld_q |=> ((secret_q & ~$past(secret_q)) == '0))
		else $error("secret bit went back to one");
	a_wip_state: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		wip_o == (st_q != SPU_ST_IDLE))
		else $error("pending flag and state disagree");
	a_unlock_paced: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(ce_i && st_q == SPU_ST_UNLOCK && pace_q <= 32'h1) |-> (pace_seen_q == 32'(UNLOCK_CYC - 1)))
		else $error("unlock pacing too short");
	c_unlock_ok: cover property (@(posedge ref_clk_i) accept && req_i.cmd == SPU_CMD_UNLOCK && match);
	c_unlock_bad: cover property (@(posedge ref_clk_i) st_q == SPU_ST_UNLOCK);
	c_psb_prog: cover property (@(posedge ref_clk_i) tmr_done && op_q.cmd == SPU_CMD_PSB_PROG);
	c_lock_clear: cover property (@(posedge ref_clk_i) accept && req_i.cmd == SPU_CMD_LOCK_CLEAR);
	c_mode_prog: cover property (@(posedge ref_clk_i) tmr_done && op_q.cmd == SPU_CMD_MODE_PROG);
endmodule // spu_top
`default_nettype wire

// *** verification/spu_host_model.sv ***
// Host-side model that issues protection commands and polls the pending flag.
`timescale 1ns/100ps
`default_nettype none
module spu_host_model
	import spu_pkg::*;
(
	// Clock
	input  wire logic     ref_clk_i,
	// Status from the device
	input  wire logic     wip_i,
	// Requests to the device
	output logic          req_valid_o,
	output var spu_req_t  req_o,
	output logic          write_en_o
);
	initial
	begin
		req_valid_o = 1'b0;
		req_o = '0;
		write_en_o = 1'b0;
	end
	// Write enable rides with every command, so no change is silently dropped.
	task automatic issue(input spu_cmd_t c, input logic [9:0] s, input logic v,
		input logic [63:0] d);
		@(negedge ref_clk_i);
		write_en_o = 1'b1;
		req_o = '{c, s, v, d};
		req_valid_o = 1'b1;
		@(negedge ref_clk_i);
		req_valid_o = 1'b0;
		write_en_o = 1'b0;
	endtask
	// The pending flag is polled under a bound before the next command.
	task automatic wait_idle(output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++)
		begin
			@(negedge ref_clk_i);
			ok = (wip_i === 1'b0);
		end
	endtask
endmodule // spu_host_model
`default_nettype wire

// *** verification/spu_top_tb.sv ***
// Self-checking bench for the sector protection unit.
`timescale 1ns/100ps
`default_nettype none
module spu_top_tb
	import spu_pkg::*;
;
	typedef struct packed {spu_cmd_t c; logic [9:0] s; logic v; logic p; logic l; logic e;} spu_row_t;
	logic ref_clk_i, rst_b_i, soft_rst_i, req_valid_i, write_en_i, block_hit_i, read_protect_i;
	logic sector_protected_o, wip_o, perr_o, lock_o, password_mode_o, cfg_write_ok_o;
	logic ecc_status_ok_o, ce_i;
	spu_req_t req_i;
	logic [1:0] mode_bits_i, mode_bits_o;
	logic [9:0] query_sector_i;
	logic [31:0] eff_read_addr_o;
	logic [63:0] secret_rdata_o;
	int bad_count = 0;
	int n_checks = 0;
	bit ok;
	spu_row_t rows [7] = '{
		'{SPU_CMD_DSB_WRITE, 10'h003, 1'b0, 1'b1, 1'b1, 1'b0},
		'{SPU_CMD_DSB_WRITE, 10'h003, 1'b1, 1'b0, 1'b1, 1'b0},
		'{SPU_CMD_PSB_PROG, 10'h005, 1'b0, 1'b1, 1'b1, 1'b0},
		'{SPU_CMD_PSB_ERASE, 10'h005, 1'b0, 1'b0, 1'b1, 1'b0},
		'{SPU_CMD_PSB_PROG, 10'h009, 1'b0, 1'b1, 1'b1, 1'b0},
		'{SPU_CMD_LOCK_CLEAR, 10'h009, 1'b0, 1'b1, 1'b0, 1'b0},
		'{SPU_CMD_PSB_ERASE, 10'h009, 1'b0, 1'b1, 1'b0, 1'b1}};
	spu_top #(.UNLOCK_CYC(20)) i_spu_top (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.ce_i(ce_i), .soft_rst_i(soft_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.write_en_i(write_en_i), .mode_bits_i(mode_bits_i), .query_sector_i(query_sector_i),
		.block_hit_i(block_hit_i), .read_protect_i(read_protect_i),
		.read_addr_i(32'h00001234), .boot_addr_i(32'h00040000),
		.sector_protected_o(sector_protected_o), .wip_o(wip_o), .perr_o(perr_o),
		.lock_o(lock_o), .password_mode_o(password_mode_o), .mode_bits_o(mode_bits_o),
		.cfg_write_ok_o(cfg_write_ok_o), .secret_rdata_o(secret_rdata_o),
		.eff_read_addr_o(eff_read_addr_o), .ecc_status_ok_o(ecc_status_ok_o));
	spu_host_model i_spu_host_model (.ref_clk_i(ref_clk_i), .wip_i(wip_o),
		.req_valid_o(req_valid_i), .req_o(req_i), .write_en_o(write_en_i));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic hard_reset(input logic [1:0] m);
		@(negedge ref_clk_i);
		rst_b_i = 1'b0;
		mode_bits_i = m;
		repeat (6) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
	endtask
	task automatic pulse_soft;
		@(negedge ref_clk_i);
		soft_rst_i = 1'b1;
		@(negedge ref_clk_i);
		soft_rst_i = 1'b0;
		@(negedge ref_clk_i);
	endtask
	task automatic run(input spu_cmd_t c, input logic [63:0] d);
		i_spu_host_model.issue(c, 10'h000, 1'b0, d);
		i_spu_host_model.wait_idle(ok);
		chk(ok, 1'b1);
	endtask
	// The run should need under a thousand cycles; this bound only cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		finish_test();
	end
	initial
	begin
		{soft_rst_i, block_hit_i, read_protect_i} = 3'h0;
		rst_b_i = 1'b0;
		ce_i = 1'b1;
		mode_bits_i = 2'h3;
		query_sector_i = 10'h000;
		hard_reset(2'h3);
		chk({sector_protected_o, lock_o, mode_bits_o}, 4'h7);
		foreach (rows[i])
		begin
			query_sector_i = rows[i].s;
			i_spu_host_model.issue(rows[i].c, rows[i].s, rows[i].v, 64'h0);
			i_spu_host_model.wait_idle(ok);
			chk(ok, 1'b1);
			chk(sector_protected_o, rows[i].p);
			chk(lock_o, rows[i].l);
			chk(perr_o, rows[i].e);
		end
		$display("table done");
		i_spu_host_model.issue(SPU_CMD_DSB_WRITE, 10'h00b, 1'b0, 64'h0);
		query_sector_i = 10'h00b;
		@(negedge ref_clk_i);
		chk(sector_protected_o, 1'b1);
		run(SPU_CMD_UNLOCK, 64'hffffffffffffffff);
		chk({lock_o, perr_o}, 2'h1);
		pulse_soft();
		chk({lock_o, perr_o}, 2'h0);
		query_sector_i = 10'h003;
		block_hit_i = 1'b1;
		#1 chk(sector_protected_o, 1'b1);
		block_hit_i = 1'b0;
		read_protect_i = 1'b1;
		#1 chk(eff_read_addr_o, 32'h00040000);
		chk(ecc_status_ok_o, 1'b0);
		read_protect_i = 1'b0;
		$display("reset and query done");
		run(SPU_CMD_SECRET_READ, 64'h0);
		chk(secret_rdata_o, 64'hffffffffffffffff);
		run(SPU_CMD_SECRET_PROG, 64'hffffffffffff00f0);
		run(SPU_CMD_SECRET_PROG, 64'hffffffffffffffff);
		run(SPU_CMD_SECRET_READ, 64'h0);
		chk(secret_rdata_o, 64'hffffffffffff00f0);
		run(SPU_CMD_MODE_PROG, 64'h0);
		chk({perr_o, mode_bits_o}, 3'h7);
		pulse_soft();
		run(SPU_CMD_MODE_PROG, 64'h2);
		chk({mode_bits_o, cfg_write_ok_o, password_mode_o}, 4'h8);
		run(SPU_CMD_CFG_WRITE, 64'h5);
		chk(perr_o, 1'b1);
		hard_reset(2'h3);
		chk(lock_o, 1'b1);
		$display("mode done");
		hard_reset(2'h1);
		chk({lock_o, password_mode_o}, 2'h1);
		run(SPU_CMD_SECRET_PROG, 64'h0);
		chk(perr_o, 1'b1);
		run(SPU_CMD_SECRET_READ, 64'h0);
		chk(secret_rdata_o, 64'h0);
		pulse_soft();
		i_spu_host_model.issue(SPU_CMD_UNLOCK, 10'h000, 1'b0, 64'h0);
		@(negedge ref_clk_i);
		chk({perr_o, wip_o, lock_o}, 3'h6);
		repeat (10) @(negedge ref_clk_i);
		chk(wip_o, 1'b1);
		ce_i = 1'b0;
		repeat (30) @(negedge ref_clk_i);
		chk({wip_o, lock_o}, 2'h2);
		ce_i = 1'b1;
		i_spu_host_model.wait_idle(ok);
		chk(ok, 1'b1);
		i_spu_host_model.issue(SPU_CMD_UNLOCK, 10'h000, 1'b0, 64'hffffffffffffffff);
		@(negedge ref_clk_i);
		chk({lock_o, wip_o}, 2'h2);
		$display("password done");
		finish_test();
	end
endmodule // spu_top_tb
`default_nettype wire
